// File: bench/host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side: register writes, done polling, sleep pin
module host_model (
	input wire logic ref_clk,
	input wire logic [15:0] regRdData,
	output var standby_reset_pkg::reg_req_t regReq,
	output logic [15:0] regAddrRd,
	output logic sleepReqPin
);
	// Idle bus, pin low
	initial begin
		regReq = '0;
		regAddrRd = 16'h0018;
		sleepReqPin = 1'b0;
	end

	// One-cycle strobe, then lines show the inverse
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk) regReq <= '{1'b1, a, d};
		@(posedge ref_clk) regReq <= '{1'b0, ~a, ~d};
	endtask

	task automatic poll(input logic v, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge ref_clk);
			#1 ok = (regRdData[14] === v);
		end
	endtask

	// Read address select, applied at the next edge
	task automatic rdAddr(input logic [15:0] a);
		@(posedge ref_clk) regAddrRd <= a;
	endtask

	task automatic pin(input int hold);
		@(posedge ref_clk) sleepReqPin <= 1'b1;
		repeat (hold) @(posedge ref_clk);
		sleepReqPin <= 1'b0;
	endtask
endmodule

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam int FRAME = 20;
	localparam int EXTRA = 10;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic serialMode = 1'b0;
	standby_reset_pkg::reg_req_t regReq;
	standby_reset_pkg::pad_ctrl_t padCtrl;
	logic [15:0] regAddrRd;
	logic [15:0] regRdData;
	logic sleepReqPin, coreRun, pipeRun, portRun, clockGateEn, internalReset, ok;
	int errTotal = 0;
	int samplesChecked = 0;
	int cycles = 0;

	standby_reset_control #(.FRAME_CYCLES(FRAME), .ENTRY_EXTRA(EXTRA)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .sleepReqPin(sleepReqPin), .regReq(regReq),
		.regAddrRd(regAddrRd), .regRdData(regRdData), .serialMode(serialMode),
		.coreRun(coreRun), .pipeRun(pipeRun), .portRun(portRun),
		.clockGateEn(clockGateEn), .internalReset(internalReset), .padCtrl(padCtrl)
	);
	host_model host (
		.ref_clk(ref_clk), .regRdData(regRdData), .regReq(regReq),
		.regAddrRd(regAddrRd), .sleepReqPin(sleepReqPin)
	);

	initial forever #2.5 ref_clk = ~ref_clk;

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic testDone;
		$display("checks=%0d mismatches=%0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Bounded wait for a level
	task automatic waitFor(ref logic s, input logic v);
		for (int i = 0; i < 100 && s !== v; i++) @(posedge ref_clk);
		#1;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			testDone();
		end
	end

	task automatic testReset;
		@(posedge ref_clk) #1;
		chk(internalReset, 1'b1);
		chk(padCtrl[17:4], 14'h0000);
		waitFor(internalReset, 1'b0);
		chk(regRdData, 16'h0000);
		chk({padCtrl.parOe[7:6], padCtrl.qualOe, padCtrl.serOe}, 7'h70);
		@(posedge ref_clk) serialMode <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 chk({padCtrl.parOe[7:6], padCtrl.qualOe, padCtrl.serOe}, 7'h0F);
		chk(padCtrl.serOut, 4'h0);
		$display("reset test done");
	endtask

	task automatic testSoft;
		host.wr(16'h0018, 16'h0001);
		#1 chk(regRdData, 16'h0001);
		repeat (FRAME + EXTRA) @(posedge ref_clk);
		#1 chk(regRdData[14], 1'b0);
		host.poll(1'b1, ok);
		chk(ok, 1'b1);
		chk({coreRun, pipeRun, portRun, clockGateEn}, 4'h2);
		chk({padCtrl.serOe, padCtrl.serOut}, 8'hF0);
		host.wr(16'h0018, 16'h0000);
		host.poll(1'b0, ok);
		chk(ok, 1'b1);
		waitFor(coreRun, 1'b1);
		chk({coreRun, portRun}, 2'h3);
		$display("soft standby test done");
	endtask

	task automatic testHard;
		fork
			host.pin(FRAME + EXTRA + 30);
			begin
				repeat (3) @(posedge ref_clk);
				#1 chk(clockGateEn, 1'b0);
				repeat (FRAME + EXTRA) @(posedge ref_clk);
				#1 chk(clockGateEn, 1'b0);
				@(posedge ref_clk);
				#1 chk({clockGateEn, coreRun, pipeRun, portRun}, 4'h8);
				chk(padCtrl.serOut, 4'h0);
				host.wr(16'h001A, 16'h0001);
				#1 chk(internalReset, 1'b0);
			end
		join
		waitFor(coreRun, 1'b1);
		chk({coreRun, portRun, clockGateEn}, 3'h6);
		$display("hard standby test done");
	endtask

	task automatic testSoftReset;
		host.wr(16'h0018, 16'h0001);
		host.wr(16'h001A, 16'h0001);
		#1 chk(internalReset, 1'b1);
		chk(padCtrl[17:4], 14'h0000);
		waitFor(internalReset, 1'b0);
		chk(regRdData, 16'h0000);
		chk(coreRun, 1'b1);
		host.rdAddr(16'h001A);
		#1 chk(regRdData, 16'h0000);
		host.rdAddr(16'h0018);
		$display("soft reset test done");
	endtask

	// Reset, then the scenarios
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		testReset();
		testSoft();
		testHard();
		testSoftReset();
		testDone();
	end
endmodule

`default_nettype wire

// File: hdl/sleep_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module sleep_pin_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pinIn,
	output logic pinSync
);

	typedef struct packed {
		logic stage1;
		logic stage2;
	} sync_state_t;

	sync_state_t state_q;
	sync_state_t state_d;

	// Two-flop chain, first stage only feeds the second
	always_comb begin
		state_d = state_q;
		state_d.stage1 = pinIn;
		state_d.stage2 = state_q.stage1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pinSync = state_q.stage2;

endmodule

`default_nettype wire

// File: hdl/standby_reset_consts.svh
`ifndef STANDBY_RESET_CONSTS_SVH
`define STANDBY_RESET_CONSTS_SVH

// Register offsets on the two-wire port
`define STBY_CTRL_OFFSET 16'h0018
`define SYS_RESET_OFFSET 16'h001A
// Field positions
`define STBY_REQ_BIT 0
`define STBY_DONE_BIT 14
`define SOFT_RESET_BIT 0
// Reset values
`define STBY_CTRL_RESET 16'h0000
// Entry timing beyond the frame, in input clock cycles
`define ENTRY_EXTRA_MIN 16742
`define ENTRY_EXTRA_MAX 17032
`define ENTRY_EXTRA_USED 16900
// Frame length default, in input clock cycles
`define FRAME_CYCLES_DEFAULT 6600000
// Power-on and soft reset hold: final count, so reset lasts 17 cycles
`define RESET_HOLD_CYCLES 16

`endif

// File: hdl/standby_reset_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "standby_reset_consts.svh"

module standby_reset_control #(
	parameter int unsigned FRAME_CYCLES = `FRAME_CYCLES_DEFAULT,
	parameter int unsigned ENTRY_EXTRA = `ENTRY_EXTRA_USED
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sleepReqPin,
	input wire standby_reset_pkg::reg_req_t regReq,
	input wire logic [15:0] regAddrRd,
	output logic [15:0] regRdData,
	input wire logic serialMode,
	output logic coreRun,
	output logic pipeRun,
	output logic portRun,
	output logic clockGateEn,
	output logic internalReset,
	output standby_reset_pkg::pad_ctrl_t padCtrl
);

	localparam int CW = 24;
	localparam int RW = 5;

	typedef struct packed {
		standby_reset_pkg::mode_t mode;
		logic hardSleep;
		logic stbyReq;
		logic stbyDone;
		logic [RW-1:0] rstCnt;
		logic [CW-1:0] entryCnt;
		logic afterReset;
	} ctrl_state_t;

	ctrl_state_t state_q;
	ctrl_state_t state_d;
	logic sleepSync;
	logic softRstWr;
	logic stbyWr;
	logic wantSleep;
	logic [CW-1:0] entryTarget;

	sleep_pin_sync syncSleep (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pinIn(sleepReqPin),
		.pinSync(sleepSync)
	);

	// Register write decode, port dead in hard standby
	// Port shut down
	assign softRstWr = regReq.wrStrobe && !state_q.hardSleep
		&& regReq.addr == `SYS_RESET_OFFSET && regReq.wrData[`SOFT_RESET_BIT];
	assign stbyWr = regReq.wrStrobe && !state_q.hardSleep && regReq.addr == `STBY_CTRL_OFFSET;
	assign wantSleep = sleepSync || state_q.stbyReq;
	assign entryTarget = CW'(FRAME_CYCLES + ENTRY_EXTRA);

	// Next-state logic
	always_comb begin
		state_d = state_q;
		if (stbyWr) begin
			state_d.stbyReq = regReq.wrData[`STBY_REQ_BIT];
		end
		case (state_q.mode)
			standby_reset_pkg::ST_RESET: begin
				state_d.stbyDone = 1'b0;
				state_d.hardSleep = 1'b0;
				state_d.stbyReq = 1'b0;
				if (state_q.rstCnt == RW'(`RESET_HOLD_CYCLES)) begin
					state_d.mode = standby_reset_pkg::ST_RUN;
					state_d.afterReset = 1'b1;
				end else begin
					state_d.rstCnt = state_q.rstCnt + 1'b1;
				end
			end
			standby_reset_pkg::ST_RUN: begin
				state_d.entryCnt = '0;
				if (wantSleep) begin
					state_d.mode = standby_reset_pkg::ST_ENTER;
					state_d.hardSleep = sleepSync;
				end
			end
			standby_reset_pkg::ST_ENTER: begin
				state_d.hardSleep = state_q.hardSleep || sleepSync;
				if (state_q.entryCnt == entryTarget - 1'b1) begin
					state_d.mode = standby_reset_pkg::ST_STANDBY;
					state_d.stbyDone = 1'b1;
				end else begin
					state_d.entryCnt = state_q.entryCnt + 1'b1;
				end
			end
			standby_reset_pkg::ST_STANDBY: begin
				// Only the pin wakes hard standby
				if (state_q.hardSleep) begin
					if (!sleepSync) begin
						state_d.mode = standby_reset_pkg::ST_EXIT;
					end
				end else if (!state_q.stbyReq && !sleepSync) begin
					state_d.mode = standby_reset_pkg::ST_EXIT;
				end
			end
			standby_reset_pkg::ST_EXIT: begin
				state_d.stbyDone = 1'b0;
				state_d.hardSleep = 1'b0;
				state_d.mode = standby_reset_pkg::ST_RUN;
			end
			default: begin
				state_d.mode = standby_reset_pkg::ST_RESET;
			end
		endcase
		if (softRstWr) begin
			state_d = '0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Register readback
	always_comb begin
		regRdData = 16'h0000;
		if (regAddrRd == `STBY_CTRL_OFFSET) begin
			regRdData[`STBY_REQ_BIT] = state_q.stbyReq;
			regRdData[`STBY_DONE_BIT] = state_q.stbyDone;
		end
	end

	// Block enables
	// Port alive in soft standby
	assign internalReset = state_q.mode == standby_reset_pkg::ST_RESET;
	assign coreRun = state_q.mode == standby_reset_pkg::ST_RUN
		|| state_q.mode == standby_reset_pkg::ST_ENTER;
	assign pipeRun = coreRun;
	assign portRun = !internalReset && !state_q.hardSleep;
	assign clockGateEn = state_q.hardSleep && state_q.mode == standby_reset_pkg::ST_STANDBY;

	// Video pad states
	// Tri-state in reset, serial low after
	always_comb begin
		padCtrl = '0;
		if (!internalReset && state_q.afterReset) begin
			if (serialMode) begin
				padCtrl.serOe = 4'hF;
			end else if (coreRun) begin
				padCtrl.parOe = 8'hFF;
				padCtrl.pixOe = 1'b1;
				padCtrl.qualOe = 1'b1;
			end
		end
	end

	// Entry ends exactly at the frame plus ENTRY_EXTRA
	entry_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(state_q.stbyDone) |-> state_q.entryCnt == entryTarget - 1'b1)
		else $error("standby done at wrong count");

	// Hard standby held while pin high
	hard_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q.mode == standby_reset_pkg::ST_STANDBY && state_q.hardSleep && sleepSync
		|=> state_q.mode == standby_reset_pkg::ST_STANDBY)
		else $error("hard standby left early");

	reset_pads_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		internalReset |-> padCtrl == '0)
		else $error("pad driven in reset");

	lp_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q.mode == standby_reset_pkg::ST_STANDBY |-> padCtrl.serOut == 4'h0
		&& padCtrl.parOe == 8'h00)
		else $error("link not in deep sleep");

	soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		softRstWr |=> internalReset && !state_q.stbyDone)
		else $error("soft reset ignored");

	port_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clockGateEn |-> !portRun && !pipeRun)
		else $error("port alive in hard standby");

	soft_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q.mode == standby_reset_pkg::ST_STANDBY && !state_q.hardSleep
		|-> portRun && !coreRun)
		else $error("soft standby state wrong");

	done_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q.mode == standby_reset_pkg::ST_EXIT && !softRstWr |=> !state_q.stbyDone
		&& state_q.mode == standby_reset_pkg::ST_RUN)
		else $error("done bit not cleared");

	// Shared pads never driven by both modes
	pad_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		padCtrl.serOe != 4'h0 |-> padCtrl.parOe[7:6] == 2'b00 && !padCtrl.qualOe)
		else $error("shared pad driven twice");

	// Synced pin request starts hard entry
	hard_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q.mode == standby_reset_pkg::ST_RUN && sleepSync && !softRstWr
		|=> state_q.mode == standby_reset_pkg::ST_ENTER && state_q.hardSleep)
		else $error("pin request not taken");

	por_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(internalReset) |-> $past(state_q.rstCnt) == RW'(`RESET_HOLD_CYCLES))
		else $error("reset hold wrong");

endmodule

`default_nettype wire

// File: hdl/standby_reset_pkg.sv
`default_nettype none

package standby_reset_pkg;

	// Top-level operating state
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_RUN = 3'b001,
		ST_ENTER = 3'b011,
		ST_STANDBY = 3'b010,
		ST_EXIT = 3'b110
	} mode_t;

	// Register access from the two-wire port
	typedef struct packed {
		logic wrStrobe;
		logic [15:0] addr;
		logic [15:0] wrData;
	} reg_req_t;

	// Video pad control toward the pad ring
	typedef struct packed {
		logic [7:0] parOe;
		logic pixOe;
		logic qualOe;
		logic [3:0] serOe;
		logic [3:0] serOut;
	} pad_ctrl_t;

endpackage

`default_nettype wire
